// ==== rtl/owc_regs.vh ====
`ifndef OWC_REGS_VH
`define OWC_REGS_VH

// Core clock rate in MHz and line timing in microseconds.
`define OWC_CLK_MHZ 250
`define OWC_TC_MIN_US 10
`define OWC_TC_MAX_US 100
`define OWC_RESET_US 12000
`define OWC_SYNC_TO_US 9000
`define OWC_GAP_US 10000

// Width of every time counter; holds the longest count with room.
`define OWC_CW 22

// Classes of a measured pulse relative to the bit period.
`define OWC_SYM_BAD 2'h0
`define OWC_SYM_HALF 2'h1
`define OWC_SYM_ONE 2'h2
`define OWC_SYM_TWO 2'h3

// Decoded commands.
`define OWC_CMD_ON 2'h1
`define OWC_CMD_OFF 2'h2
`define OWC_CMD_LATCH 2'h3

// Falling edges seen after the first one of the start-and-sync part.
`define OWC_SYNC_FALLS 2'h3

`endif

// ==== rtl/owc_sync.v ====
`timescale 1ns/1ps

module owc_sync (
   input wire core_clk,
   input wire rst,
   input wire async_in,
   output reg sync_out
);

   reg meta_reg;

   // The line idles high, so both stages reset high to avoid a false edge.
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ==== rtl/owc_rx.v ====
`timescale 1ns/1ps
`include "owc_regs.vh"

module owc_rx #(
   parameter [`OWC_CW-1:0] RESET_CYC = `OWC_RESET_US * `OWC_CLK_MHZ,
   parameter [`OWC_CW-1:0] SYNC_TO_CYC = `OWC_SYNC_TO_US * `OWC_CLK_MHZ,
   parameter [`OWC_CW-1:0] GAP_CYC = `OWC_GAP_US * `OWC_CLK_MHZ,
   parameter [`OWC_CW-1:0] TC_MAX_CYC = `OWC_TC_MAX_US * `OWC_CLK_MHZ
) (
   input wire core_clk,
   input wire rst,
   input wire line_in,
   output reg line_out,
   output reg led_en,
   output reg path_closed
);

   localparam [`OWC_CW-1:0] TC_MIN_CYC = `OWC_TC_MIN_US * `OWC_CLK_MHZ;
   // Accepted span of three bit periods, with half a period of slack.
   localparam [`OWC_CW-1:0] T3_MIN = (TC_MIN_CYC << 1) + (TC_MIN_CYC >> 1);
   localparam [`OWC_CW-1:0] T3_MAX = (TC_MAX_CYC << 1) + TC_MAX_CYC +
                                     (TC_MAX_CYC >> 1);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_SYNC = 3'h1;
   localparam [2:0] ST_GAP = 3'h2;
   localparam [2:0] ST_LOW1 = 3'h3;
   localparam [2:0] ST_MID = 3'h4;
   localparam [2:0] ST_LOW2 = 3'h5;
   localparam [2:0] ST_STOP = 3'h6;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [`OWC_CW-1:0] cnt_reg;
   reg [`OWC_CW-1:0] cnt_next;
   reg [`OWC_CW-1:0] t3_reg;
   reg [`OWC_CW-1:0] t3_next;
   reg [`OWC_CW-1:0] low_cnt_reg;
   reg [1:0] falls_reg;
   reg [1:0] falls_next;
   reg [1:0] cmd_reg;
   reg [1:0] cmd_next;
   reg buf_reg;
   reg buf_next;
   reg sw_next;
   reg led_next;
   reg din_d_reg;
   wire din_s;
   wire fall;
   wire rise;
   wire bus_reset;
   wire stop_done;
   wire [1:0] sym;

   // Classifies a pulse length against three bit periods: 12*len vs t3.
   function [1:0] sym_class;
      input [`OWC_CW-1:0] len;
      input [`OWC_CW-1:0] t3;
      reg [`OWC_CW+3:0] x;
      reg [`OWC_CW+3:0] t1;
      reg [`OWC_CW+3:0] t3x;
      reg [`OWC_CW+3:0] t10;
      begin
         x = ({4'h0, len} << 3) + ({4'h0, len} << 2);
         t1 = {4'h0, t3};
         t3x = t1 + (t1 << 1);
         t10 = (t1 << 3) + (t1 << 1);
         if (x < t1) begin
            sym_class = `OWC_SYM_BAD;
         end else if (x < t3x) begin
            sym_class = `OWC_SYM_HALF;
         end else if (x < (t3x << 1)) begin
            sym_class = `OWC_SYM_ONE;
         end else if (x < t10) begin
            sym_class = `OWC_SYM_TWO;
         end else begin
            sym_class = `OWC_SYM_BAD;
         end
      end
   endfunction

   owc_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(line_in),
      .sync_out(din_s)
   );

   assign fall = din_d_reg & ~din_s;
   assign rise = ~din_d_reg & din_s;
   assign bus_reset = ~din_s & (low_cnt_reg >= RESET_CYC);
   // Pulse widths are judged against the rate from the last sync.
   assign sym = sym_class(cnt_reg, t3_reg);
   // Stop is accepted after 1.5 bit periods of high.
   assign stop_done = ({cnt_reg, 1'b0} >= {1'b0, t3_reg});

   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg + {{(`OWC_CW-1){1'b0}}, 1'b1};
      t3_next = t3_reg;
      falls_next = falls_reg;
      cmd_next = cmd_reg;
      buf_next = buf_reg;
      sw_next = path_closed;
      led_next = led_en;
      case (state_reg)
         ST_IDLE: begin
            cnt_next = {`OWC_CW{1'b0}};
            falls_next = 2'h0;
            if (fall) begin
               state_next = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (cnt_reg >= SYNC_TO_CYC) begin
               state_next = ST_IDLE;
            end else if (fall) begin
               falls_next = falls_reg + 2'h1;
               if (falls_reg == `OWC_SYNC_FALLS - 2'h1) begin
                  // Fourth falling edge: three periods measured.
                  cnt_next = {`OWC_CW{1'b0}};
                  if (cnt_reg >= T3_MIN && cnt_reg <= T3_MAX) begin
                     t3_next = cnt_reg;
                     state_next = ST_GAP;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
         end
         ST_GAP: begin
            // Gap limit counts from the last sync fall, so add one span.
            if (cnt_reg >= GAP_CYC + t3_reg) begin
               state_next = ST_IDLE;
            end else if (fall) begin
               cnt_next = {`OWC_CW{1'b0}};
               state_next = ST_LOW1;
            end
         end
         ST_LOW1: begin
            if (rise) begin
               cnt_next = {`OWC_CW{1'b0}};
               state_next = ST_STOP;
               if (sym == `OWC_SYM_HALF) begin
                  state_next = ST_MID;
               end else if (sym == `OWC_SYM_ONE) begin
                  cmd_next = `OWC_CMD_ON;
               end else if (sym == `OWC_SYM_TWO) begin
                  cmd_next = `OWC_CMD_LATCH;
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_MID: begin
            if (fall) begin
               cnt_next = {`OWC_CW{1'b0}};
               if (sym == `OWC_SYM_ONE) begin
                  state_next = ST_LOW2;
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_LOW2: begin
            if (rise) begin
               cnt_next = {`OWC_CW{1'b0}};
               if (sym == `OWC_SYM_HALF) begin
                  cmd_next = `OWC_CMD_OFF;
                  state_next = ST_STOP;
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_STOP: begin
            if (fall) begin
               state_next = ST_IDLE;
            end else if (stop_done) begin
               state_next = ST_IDLE;
               if (cmd_reg == `OWC_CMD_LATCH) begin
                  led_next = buf_reg;
                  sw_next = 1'b0;
               end else if (!path_closed) begin
                  buf_next = (cmd_reg == `OWC_CMD_ON);
                  sw_next = 1'b1;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // Any other stall past the gap limit falls back to standby.
      if (state_reg != ST_IDLE && state_reg != ST_SYNC &&
          state_reg != ST_GAP && cnt_reg >= GAP_CYC) begin
         state_next = ST_IDLE;
      end
      if (bus_reset) begin
         state_next = ST_IDLE;
         sw_next = 1'b0;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= {`OWC_CW{1'b0}};
         t3_reg <= T3_MIN;
         low_cnt_reg <= {`OWC_CW{1'b0}};
         falls_reg <= 2'h0;
         cmd_reg <= 2'h0;
         buf_reg <= 1'b0;
         path_closed <= 1'b0;
         led_en <= 1'b0;
         line_out <= 1'b1;
         din_d_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         t3_reg <= t3_next;
         falls_reg <= falls_next;
         cmd_reg <= cmd_next;
         buf_reg <= buf_next;
         path_closed <= sw_next;
         led_en <= led_next;
         din_d_reg <= din_s;
         // Saturates so a held-low line keeps the reset asserted.
         if (din_s) begin
            low_cnt_reg <= {`OWC_CW{1'b0}};
         end else if (low_cnt_reg < RESET_CYC) begin
            low_cnt_reg <= low_cnt_reg + {{(`OWC_CW-1){1'b0}}, 1'b1};
         end
         // Three flops of delay with the synchroniser; far below the allowed pass-through lag.
         line_out <= path_closed ? din_s : 1'b1;
      end
   end

endmodule

// ==== sim/owc_rx_monitor.sv ====
`timescale 1ns/1ps
module owc_rx_monitor #(
   parameter [21:0] RESET_CYC = 22'h2DC6C0
) (
   input wire core_clk,
   input wire rst,
   input wire line_in,
   input wire line_out,
   input wire led_en,
   input wire path_closed
);
   // Shortest stop high that may apply a command: 1.5 of a 2500 cycle bit.
   localparam int HI_MIN = 3750;
   reg [21:0] hi_cnt_reg;
   reg [21:0] lo_cnt_reg;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hi_cnt_reg <= 22'h000000;
         lo_cnt_reg <= 22'h000000;
      end else begin
         hi_cnt_reg <= line_in ? hi_cnt_reg + 22'h000001 : 22'h000000;
         lo_cnt_reg <= line_in ? 22'h000000 : lo_cnt_reg + 22'h000001;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_rst_vals;
      disable iff (1'b0) rst |-> line_out && !led_en && !path_closed;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("outputs not at reset values");
   property p_open_idle;
      !path_closed && !$past(path_closed) |-> line_out;
   endproperty
   a_open_idle: assert property (p_open_idle)
      else $error("open path does not rest high");
   property p_follow;
      path_closed && $past(path_closed) && $past(path_closed, 2)
         && $past(path_closed, 3) |-> line_out == $past(line_in, 3);
   endproperty
   a_follow: assert property (p_follow)
      else $error("closed path does not forward the line");
   // A latch may also arrive with the path already open, so the stop high
   // is the cause to look for, not the opening of the path.
   property p_led_latch;
      $changed(led_en) |-> !path_closed && hi_cnt_reg >= HI_MIN;
   endproperty
   a_led_latch: assert property (p_led_latch)
      else $error("output stage changed without a latch");
   property p_close_stop;
      $rose(path_closed) |-> hi_cnt_reg >= HI_MIN && $stable(led_en);
   endproperty
   a_close_stop: assert property (p_close_stop)
      else $error("path closed before a full stop");
   property p_open_cause;
      $fell(path_closed) |-> hi_cnt_reg >= HI_MIN || lo_cnt_reg >= RESET_CYC;
   endproperty
   a_open_cause: assert property (p_open_cause)
      else $error("path opened without latch or bus reset");
   property p_reset_open;
      lo_cnt_reg >= RESET_CYC + 22'h000008 |-> !path_closed;
   endproperty
   a_reset_open: assert property (p_reset_open)
      else $error("long low did not open the path");
   property p_hold_closed;
      $rose(path_closed) |=> path_closed [*8];
   endproperty
   a_hold_closed: assert property (p_hold_closed)
      else $error("closed path did not hold");
endmodule
bind owc_rx owc_rx_monitor #(.RESET_CYC(RESET_CYC)) mon_u (
   .core_clk(core_clk), .rst(rst), .line_in(line_in),
   .line_out(line_out), .led_en(led_en), .path_closed(path_closed));

// ==== sim/owc_host.sv ====
`timescale 1ns/1ps
module owc_host #(
   parameter HALF = 1250
) (
   input wire core_clk,
   output reg line
);
   // Only this model drives the line, and it rests high.
   initial line = 1'b1;
   task wait_cyc(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   // MSB first, half a bit per SPI bit, line held at each data bit's level.
   task send_byte(input [7:0] d);
      integer i;
      for (i = 7; i >= 0; i = i - 1) begin
         @(posedge core_clk);
         #1 line = d[i];
         wait_cyc(HALF - 1);
      end
   endtask
   // Sync byte, high gap, then the data byte, whose trailing ones form the stop.
   task send_frame(input [7:0] d);
      send_byte(8'h55);
      wait_cyc(1000);
      send_byte(d);
   endtask
   task bus_low(input integer n);
      @(posedge core_clk);
      #1 line = 1'b0;
      wait_cyc(n);
      #1 line = 1'b1;
   endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   localparam [21:0] RST_CYC = 22'h001770;
   localparam [21:0] SYNC_CYC = 22'h002000;
   reg core_clk;
   reg rst;
   wire line_in;
   wire line_out;
   wire led_en;
   wire path_closed;
   integer bad_count = 0;
   integer samples_checked = 0;
   integer cyc = 0;
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   owc_host host_u (.core_clk(core_clk), .line(line_in));
   // The sync timeout sits just above the 7500 cycle span of every sync used.
   owc_rx #(.RESET_CYC(RST_CYC), .SYNC_TO_CYC(SYNC_CYC)) dut_u (
      .core_clk(core_clk), .rst(rst), .line_in(line_in),
      .line_out(line_out), .led_en(led_en), .path_closed(path_closed));
   task chk(input [8*8-1:0] name, input logic exp, input logic got);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %0s expected %b seen %b", name, exp, got);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 105000) begin
         bad_count = bad_count + 1;
         finish_test;
      end
   end
   task t_on;
      chk("path", 1'b0, path_closed);
      chk("dout", 1'b1, line_out);
      host_u.send_frame(8'h9F);
      chk("path", 1'b1, path_closed);
      chk("led", 1'b0, led_en);
      $display("t_on done");
   endtask
   task t_ignored;
      host_u.send_frame(8'h6F);
      chk("path", 1'b1, path_closed);
      $display("t_ignored done");
   endtask
   task t_latch;
      host_u.send_frame(8'h0F);
      chk("path", 1'b0, path_closed);
      chk("led", 1'b1, led_en);
      chk("dout", 1'b1, line_out);
      $display("t_latch done");
   endtask
   // A lone glitch must time out, or the next sync span is mismeasured.
   task t_sync_timeout;
      host_u.bus_low(4);
      host_u.wait_cyc(SYNC_CYC + 200);
      host_u.send_frame(8'h6F);
      chk("path", 1'b1, path_closed);
      $display("t_sync_timeout done");
   endtask
   task t_off_reset;
      chk("path", 1'b1, path_closed);
      host_u.bus_low(RST_CYC + 20);
      host_u.wait_cyc(4);
      chk("path", 1'b0, path_closed);
      chk("led", 1'b1, led_en);
      $display("t_off_reset done");
   endtask
   initial begin
      rst = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      t_on;
      t_ignored;
      t_latch;
      t_sync_timeout;
      t_off_reset;
      finish_test;
   end
endmodule
